/* hdl/psd_defs.vh */
`ifndef PSD_DEFS_VH
`define PSD_DEFS_VH
`define PSD_CODE_W       5
`define PSD_MODE_STOP    5'h00
`define PSD_MODE_FREE    5'h08
`define PSD_MODE_ANG_HI  5'h19
`define PSD_MODE_ANG_LO  5'h1a
`define PSD_MODE_SYN_HI  5'h1b
`define PSD_MODE_SYN_LO  5'h1c
`define PSD_MODE_XSTEPS  5'h1d
`define PSD_CLK_HZ       26'h1312d00
`define PSD_ACC_W        26
`define PSD_DET_N        2
`define PSD_DET_SYNC     0
`define PSD_DET_ANG      1
`define PSD_RATE_RESET   16'h0140
`define PSD_Q1           2'h0
`define PSD_Q2           2'h2
`define PSD_Q3           2'h1
`define PSD_Q4           2'h3
`endif

/* hdl/psd_drive.v */
`timescale 1ns/1ps
`include "psd_defs.vh"
module psd_drive #(
	parameter RATE_W  = 16,
	parameter COUNT_W = 24,
	parameter TALLY_W = 32
) (
	input  wire               i_clk,
	input  wire               i_reset,
	input  wire               i_motion_select_command,
	input  wire [7:0]         i_motion_code,
	input  wire [COUNT_W-1:0] i_step_count,
	input  wire               i_step_rate_setting,
	input  wire [RATE_W-1:0]  i_step_rate,
	input  wire               i_motor_controller_reinit,
	input  wire               i_sync_detector,
	input  wire               i_angle_detector,
	output reg  [RATE_W-1:0]  o_step_rate_query,
	output reg  [TALLY_W-1:0] o_steps_moved_tally,
	output reg                o_tally_valid,
	output reg  [1:0]         o_quadrant,
	output reg                o_sync_detector_level,
	output reg                o_angle_detector_level,
	output reg  [4:0]         o_motion_code,
	output reg                o_step,
	output reg                o_busy
);
	////////////////////////////////////////////////////////////////////////////////
	// Detector synchronisers: two flops per pin, then a level flop and a history flop
	// Both pins share one structure, so both see the same latency.
	wire [`PSD_DET_N-1:0] det_pin;
	wire [`PSD_DET_N-1:0] det_lvl;
	wire [`PSD_DET_N-1:0] det_prev;
	wire                  sync_lvl;
	wire                  ang_lvl;
	wire                  sync_prev;
	wire                  ang_prev;
	wire                  sync_rise;
	wire                  ang_rise;

	assign det_pin[`PSD_DET_SYNC] = i_sync_detector;
	assign det_pin[`PSD_DET_ANG]  = i_angle_detector;

	genvar g;
	generate
		for (g = 0; g < `PSD_DET_N; g = g + 1)
		begin : g_det
			reg [1:0] meta;
			reg       lvl;
			reg       prev;

			always @(posedge i_clk)
			begin
				if (i_reset)
				begin
					meta <= 2'h0;
					lvl  <= 1'b0;
					prev <= 1'b0;
				end
				else
				begin
					meta <= {meta[0], det_pin[g]};
					lvl  <= meta[1];
					prev <= lvl;
				end
			end

			assign det_lvl[g]  = lvl;
			assign det_prev[g] = prev;
		end
	endgenerate

	assign sync_lvl  = det_lvl[`PSD_DET_SYNC];
	assign ang_lvl   = det_lvl[`PSD_DET_ANG];
	assign sync_prev = det_prev[`PSD_DET_SYNC];
	assign ang_prev  = det_prev[`PSD_DET_ANG];

	// Edges seen on synchronised levels only, so a glitch on a pin cannot double count
	assign sync_rise = sync_lvl & ~sync_prev;
	assign ang_rise  = ang_lvl & ~ang_prev;

	////////////////////////////////////////////////////////////////////////////////
	// Rate setting and mode register
	reg  [RATE_W-1:0]  rate;
	reg  [4:0]         mode;
	reg  [COUNT_W-1:0] remain;
	reg  [TALLY_W-1:0] tally;
	reg                run;
	wire               tick;
	wire [4:0]         code_in;

	assign code_in = i_motion_code[4:0];

	always @(posedge i_clk)
	begin
		if (i_reset)
			rate <= `PSD_RATE_RESET;
		else if (i_step_rate_setting)
			rate <= i_step_rate;
	end

	// Motion class, latched together with the code, tells which permission applies
	localparam [1:0] CLS_STOP  = 2'h0;
	localparam [1:0] CLS_FREE  = 2'h1;
	localparam [1:0] CLS_COND  = 2'h2;
	localparam [1:0] CLS_COUNT = 2'h3;

	reg  [1:0] cls;
	reg  [1:0] next_cls;
	reg  [1:0] code_cls;
	reg        cond_ok;

	// Detector condition of the latched code; codes outside the table never pass
	always @*
	begin
		case (mode)
		`PSD_MODE_ANG_HI: cond_ok = ang_lvl;
		`PSD_MODE_ANG_LO: cond_ok = !ang_lvl;
		`PSD_MODE_SYN_HI: cond_ok = sync_lvl;
		`PSD_MODE_SYN_LO: cond_ok = !sync_lvl;
		default:          cond_ok = 1'b0;
		endcase
	end

	// Stepping permission per class, evaluated on synchronised levels
	always @*
	begin
		case (cls)
		CLS_FREE:  run = 1'b1;
		CLS_COND:  run = cond_ok;
		CLS_COUNT: run = (remain != {COUNT_W{1'b0}});
		default:   run = 1'b0;
		endcase
	end

	// Class of an incoming code; unknown codes act as stop but are still reported
	always @*
	begin
		case (code_in)
		`PSD_MODE_FREE:   code_cls = CLS_FREE;
		`PSD_MODE_ANG_HI: code_cls = CLS_COND;
		`PSD_MODE_ANG_LO: code_cls = CLS_COND;
		`PSD_MODE_SYN_HI: code_cls = CLS_COND;
		`PSD_MODE_SYN_LO: code_cls = CLS_COND;
		`PSD_MODE_XSTEPS: code_cls = CLS_COUNT;
		default:          code_cls = CLS_STOP;
		endcase
	end

	psd_rate_gen #(
		.RATE_W (RATE_W),
		.ACC_W  (`PSD_ACC_W)
	) u_rate (
		.i_clk   (i_clk),
		.i_reset (i_reset | i_motor_controller_reinit),
		.i_run   (run),
		.i_rate  (rate),
		.o_tick  (tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Motion control, step tally
	// A step pulse in the command cycle counts toward the closing tally, so none is lost.
	wire               step_now;
	wire               is_count_mode;
	reg  [4:0]         next_mode;
	reg  [COUNT_W-1:0] next_remain;
	reg  [TALLY_W-1:0] next_tally;
	reg  [TALLY_W-1:0] next_report;
	reg                next_valid;

	assign step_now      = tick & run;
	assign is_count_mode = (cls == CLS_COUNT);

	always @*
	begin
		next_mode   = mode;
		next_cls    = cls;
		next_remain = remain;
		next_tally  = tally;
		next_report = o_steps_moved_tally;
		next_valid  = 1'b0;
		if (i_motion_select_command)
		begin
			next_mode   = code_in;
			next_cls    = code_cls;
			next_report = tally + {{(TALLY_W-1){1'b0}}, step_now};
			next_valid  = 1'b1;
			next_tally  = {TALLY_W{1'b0}};
			if (code_in == `PSD_MODE_XSTEPS)
				next_remain = i_step_count;
			else
				next_remain = {COUNT_W{1'b0}};
		end
		else if (step_now)
		begin
			next_tally = tally + {{(TALLY_W-1){1'b0}}, 1'b1};
			if (is_count_mode)
				next_remain = remain - {{(COUNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Reinit clears motion and tally but keeps the programmed rate
	always @(posedge i_clk)
	begin
		if (i_reset || i_motor_controller_reinit)
		begin
			mode                <= `PSD_MODE_STOP;
			cls                 <= CLS_STOP;
			remain              <= {COUNT_W{1'b0}};
			tally               <= {TALLY_W{1'b0}};
			o_steps_moved_tally <= {TALLY_W{1'b0}};
			o_tally_valid       <= 1'b0;
			o_step              <= 1'b0;
		end
		else
		begin
			mode                <= next_mode;
			cls                 <= next_cls;
			remain              <= next_remain;
			tally               <= next_tally;
			o_steps_moved_tally <= next_report;
			o_tally_valid       <= next_valid;
			o_step              <= step_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Quadrant tracker: restart at the sync position, advance on each angle edge
	reg [1:0] quad;
	reg [1:0] next_quad;

	// A sync edge and an angle edge together: sync wins and the turn restarts
	always @*
	begin
		next_quad = quad;
		if (sync_rise)
			next_quad = `PSD_Q4; // Next angle mark opens the first quadrant
		else if (ang_rise)
		begin
			case (quad)
			`PSD_Q1: next_quad = `PSD_Q2;
			`PSD_Q2: next_quad = `PSD_Q3;
			`PSD_Q3: next_quad = `PSD_Q4;
			default: next_quad = `PSD_Q1;
			endcase
		end
	end

	// Quadrant is undefined until the first sync mark; it starts as if one just passed
	always @(posedge i_clk)
	begin
		if (i_reset)
			quad <= `PSD_Q4;
		else
			quad <= next_quad;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status outputs
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_step_rate_query      <= `PSD_RATE_RESET;
			o_quadrant             <= `PSD_Q4;
			o_sync_detector_level  <= 1'b0;
			o_angle_detector_level <= 1'b0;
			o_motion_code          <= `PSD_MODE_STOP;
			o_busy                 <= 1'b0;
		end
		else
		begin
			o_step_rate_query      <= rate;
			o_quadrant             <= quad;
			o_sync_detector_level  <= sync_lvl;
			o_angle_detector_level <= ang_lvl;
			o_motion_code          <= mode;
			o_busy                 <= run;
		end
	end
endmodule

/* hdl/psd_rate_gen.v */
`timescale 1ns/1ps
`include "psd_defs.vh"
// Phase accumulator: adds the rate each clock while running, ticks when the sum reaches the clock rate.
// Spacing jitters by at most one clock, average rate is exact.
module psd_rate_gen #(
	parameter RATE_W = 16,
	parameter ACC_W  = 26
) (
	input  wire              i_clk,
	input  wire              i_reset,
	input  wire              i_run,
	input  wire [RATE_W-1:0] i_rate,
	output reg               o_tick
);
	localparam [ACC_W-1:0] CLK_HZ = `PSD_CLK_HZ;

	reg  [ACC_W-1:0] acc;
	wire [ACC_W-1:0] sum;

	assign sum = acc + {{(ACC_W-RATE_W){1'b0}}, i_rate};

	always @(posedge i_clk)
	begin
		if (i_reset || !i_run)
		begin
			acc <= {ACC_W{1'b0}};
			o_tick <= 1'b0;
		end
		else if (sum >= CLK_HZ)
		begin
			acc <= sum - CLK_HZ;
			o_tick <= 1'b1;
		end
		else
		begin
			acc <= sum;
			o_tick <= 1'b0;
		end
	end
endmodule

/* test/psd_drive_assertions.sv */
`timescale 1ns/1ps
module psd_drive_chk (
	input wire        i_clk,
	input wire        i_reset,
	input wire        i_motion_select_command,
	input wire [7:0]  i_motion_code,
	input wire        i_motor_controller_reinit,
	input wire        i_sync_detector,
	input wire        i_angle_detector,
	input wire        o_tally_valid,
	input wire        o_sync_detector_level,
	input wire        o_angle_detector_level,
	input wire [4:0]  o_motion_code,
	input wire        o_step,
	input wire        o_busy
);
default clocking @(posedge i_clk);
endclocking
default disable iff (i_reset);
sequence s_stopped;
	(o_motion_code == 5'h00)[*4];
endsequence
sequence s_count_done;
	(o_motion_code == 5'h1d && !o_busy)[*2];
endsequence
sequence s_sync_gone;
	(o_motion_code == 5'h1b && !o_sync_detector_level)[*3];
endsequence
AST_TALLY: assert property (i_motion_select_command && !i_motor_controller_reinit |=> o_tally_valid)
	else $error("tally");
AST_CODE: assert property (i_motion_select_command && !i_motor_controller_reinit |=> ##1
	{3'h0, o_motion_code} == ($past(i_motion_code, 2) & 8'h1f)) else $error("code");
AST_REINIT: assert property (i_motor_controller_reinit |=> ##1 o_motion_code == 5'h00 && !o_busy)
	else $error("reinit");
AST_SYNC_LVL: assert property (o_sync_detector_level == $past(i_sync_detector, 4))
	else $error("sync");
AST_ANG_LVL: assert property (o_angle_detector_level == $past(i_angle_detector, 4))
	else $error("angle");
AST_IDLE: assert property (s_stopped |-> !o_step) else $error("idle");
AST_DONE: assert property (s_count_done |-> !o_step) else $error("done");
AST_SYNC_STOP: assert property (s_sync_gone |-> !o_step) else $error("syncstop");
endmodule
bind psd_drive psd_drive_chk i_psd_drive_chk (.*);

/* test/psd_motor.sv */
`timescale 1ns/1ps
module psd_motor (
	input  wire        i_clk,
	input  wire        i_step,
	output wire        o_sync,
	output wire        o_angle,
	output reg  [31:0] o_pos
);
initial o_pos = 0;
always @(posedge i_clk)
	if (i_step)
		o_pos <= o_pos + 1;
// Sixteen steps a turn: sync mark spans two steps, four angle marks
assign o_sync = o_pos[3:1] == 3'h7;
assign o_angle = o_pos[1:0] == 2'h1;
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
reg clk = 0, rst = 1, sel = 0, rw = 0, ri = 0;
reg [7:0] code = 0;
reg [23:0] cnt = 0;
wire [31:0] tal, pos;
wire [15:0] rq;
wire [4:0] mc;
wire [2:0] lv;
wire [1:0] q;
wire tv, stp, sy, an;
integer mismatches = 0, tests_run = 0, t1;
always #25 clk = ~clk;
// Rate of 20000 steps/s keeps the run short yet slow beside the detector latency
psd_drive i_psd_drive (.i_clk(clk), .i_reset(rst), .i_motion_select_command(sel),
	.i_motion_code(code), .i_step_count(cnt), .i_step_rate_setting(rw),
	.i_step_rate(16'h4e20), .i_motor_controller_reinit(ri), .i_sync_detector(sy),
	.i_angle_detector(an), .o_step_rate_query(rq), .o_steps_moved_tally(tal),
	.o_tally_valid(tv), .o_quadrant(q), .o_sync_detector_level(lv[0]),
	.o_angle_detector_level(lv[1]), .o_motion_code(mc), .o_step(stp), .o_busy(lv[2]));
psd_motor i_psd_motor (.i_clk(clk), .i_step(stp), .o_sync(sy), .o_angle(an), .o_pos(pos));
task cmp(input [31:0] s, input [31:0] e);
begin
	tests_run = tests_run + 1;
	if (s !== e)
	begin
		mismatches = mismatches + 1;
		$display("BAD %0t %h %h", $time, s, e);
	end
end
endtask
task end_sim;
begin
	$display("%0d checks, %0d bad", tests_run, mismatches);
	if (mismatches == 0 && tests_run > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
end
endtask
task cmd(input [7:0] c, input [23:0] n, input [31:0] e);
begin
	@(negedge clk);
	code = c;
	cnt = n;
	sel = 1;
	@(negedge clk);
	sel = 0;
	cmp(tv, 1);
	cmp(tal, e);
	@(negedge clk);
	cmp(mc, c[4:0]);
end
endtask
task w(input integer k, input v);
	integer n;
begin
	for (n = 0; n < 16000 && lv[k] !== v; n = n + 1)
		@(negedge clk);
	if (n == 16000)
	begin
		cmp(0, 1);
		end_sim;
	end
end
endtask
initial
begin
	repeat (4) @(negedge clk);
	rst = 0;
	cmp({rq, q, lv, mc}, 32'h50300);
	rw = 1;
	@(negedge clk);
	rw = 0;
	repeat (2) @(negedge clk);
	cmp(rq, 16'h4e20);
	$display("T1 done");
	cmd(8'hfd, 3, 0);
	repeat (4000) @(negedge clk);
	cmp({pos[30:0], lv[2]}, 6);
	cmd(0, 0, 3);
	cmd(8'h1c, 0, 0);
	w(0, 1);
	cmd(8'h1b, 0, 11);
	w(0, 0);
	cmd(8'h1c, 0, 2);
	w(0, 1);
	cmd(8'h1b, 0, 14);
	w(0, 0);
	cmd(0, 0, 2);
	cmp(q, 2'h3);
	$display("T2 done");
	cmd(8'h1a, 0, 0);
	w(1, 1);
	cmd(8'h19, 0, 1);
	cmp(q, 2'h0);
	w(1, 0);
	cmd(8'h1a, 0, 1);
	w(1, 1);
	cmd(8'h08, 0, 3);
	cmp(q, 2'h2);
	$display("T3 done");
	t1 = pos;
	repeat (10050) @(negedge clk);
	cmp((pos - t1) / 2, 5);
	cmd(0, 0, pos - t1);
	ri = 1;
	@(negedge clk);
	ri = 0;
	t1 = pos;
	repeat (2100) @(negedge clk);
	cmp(pos - t1 + mc, 0);
	$display("T4 done");
	end_sim;
end
endmodule
